// ===== logic/tcc_pkg.sv
// Shared constants of the three-channel timer core
package tcc_pkg;

  // ********************************************************
  // Sizes
  // ********************************************************
  localparam int          NUM_CH     = 3;
  localparam int          NUM_GR     = 8;
  localparam int          GR_BASE[3] = '{0, 4, 6};

  // ********************************************************
  // Values after reset and counter limits
  // ********************************************************
  localparam logic [15:0] CNT_INIT   = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] CNT_STEP   = 16'h0001;
  localparam logic [15:0] GR_INIT    = 16'hFFFF;
  localparam logic        PIN_INIT   = 1'b0;
  localparam logic [2:0]  FLAG3_INIT = 3'h0;
  localparam logic [1:0]  FLAG2_INIT = 2'h0;
  localparam logic [7:0]  FLAG8_INIT = 8'h00;

  // ********************************************************
  // Counter clear source codes (3 bits per channel)
  // ********************************************************
  localparam logic [2:0]  CLR_NONE   = 3'h0;
  localparam logic [2:0]  CLR_GA     = 3'h1;
  localparam logic [2:0]  CLR_GB     = 3'h2;
  localparam logic [2:0]  CLR_SYNC   = 3'h3;
  localparam logic [2:0]  CLR_GC     = 3'h5;
  localparam logic [2:0]  CLR_GD     = 3'h6;

  // ********************************************************
  // Pin control field (4 bits per general register)
  // ********************************************************
  localparam int          IO_ACT_LSB  = 0;
  localparam int          IO_INIT_BIT = 2;
  localparam int          IO_CAP_BIT  = 3;
  localparam logic [1:0]  ACT_NONE    = 2'h0;
  localparam logic [1:0]  ACT_LOW     = 2'h1;
  localparam logic [1:0]  ACT_HIGH    = 2'h2;
  localparam logic [1:0]  ACT_TOGGLE  = 2'h3;
  localparam logic [1:0]  EDGE_RISE   = 2'h1;
  localparam logic [1:0]  EDGE_FALL   = 2'h2;
  localparam logic [1:0]  EDGE_BOTH   = 2'h3;

endpackage : tcc_pkg

// ===== logic/tcc_counter.sv
// One 16-bit channel counter with load, clear and wrap detection
`timescale 1ns/1ps
`default_nettype none
module tcc_counter
  import tcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        adv,
  input  wire logic        up,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic        clr,
  output logic      [15:0] cnt,
  output logic             ovf,
  output logic             unf
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic [15:0] cnt_step;

  // ********************************************************
  // Next count: load beats clear beats counting
  // ********************************************************
  assign cnt_step = up ? (cnt_reg + CNT_STEP) : (cnt_reg - CNT_STEP);
  assign cnt_next = load ? load_val : (clr ? CNT_INIT : (adv ? cnt_step : cnt_reg));
  assign ovf      = adv & up & ~load & ~clr & (cnt_reg == CNT_MAX);
  assign unf      = adv & ~up & ~load & ~clr & (cnt_reg == CNT_INIT);
  assign cnt      = cnt_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= CNT_INIT;
    end else if (ce) begin
      cnt_reg <= cnt_next;
    end
  end

endmodule : tcc_counter
`default_nettype wire

// ===== logic/tcc_greg.sv
// One general register: compare or capture, buffer load and pin output
`timescale 1ns/1ps
`default_nettype none
module tcc_greg
  import tcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [15:0] cnt,
  input  wire logic        adv,
  input  wire logic        run,
  input  wire logic [3:0]  io_ctrl,
  input  wire logic        io_wr,
  input  wire logic        gr_wr,
  input  wire logic [15:0] wdata,
  input  wire logic        ld,
  input  wire logic [15:0] ld_val,
  input  wire logic        pwm_clr,
  input  wire logic        pin_in,
  output logic      [15:0] gr,
  output logic             evt,
  output logic             is_cap,
  output logic             pin_out,
  output logic             pin_oe
);

  logic [15:0] gr_reg;
  logic [15:0] gr_next;
  logic        prev_reg;
  logic        pin_reg;
  logic        pin_next;
  logic        cmp_level;
  logic        cap_mode;
  logic [1:0]  act;
  logic        rise;
  logic        fall;
  logic        match;

  // ********************************************************
  // Compare and capture decode
  // ********************************************************
  assign cap_mode = io_ctrl[IO_CAP_BIT];
  assign act      = io_ctrl[IO_ACT_LSB +: 2];
  assign rise     = pin_in & ~prev_reg;
  assign fall     = ~pin_in & prev_reg;
  assign is_cap   = cap_mode & (((act == EDGE_RISE) & rise) | ((act == EDGE_FALL) & fall)
                    | ((act == EDGE_BOTH) & (rise | fall)));
  // Match only on an advancing tick, so a halted counter never repeats it
  assign match    = ~cap_mode & adv & (cnt == gr_reg);
  assign evt      = is_cap | match;
  assign gr_next  = gr_wr ? wdata : (is_cap ? cnt : (ld ? ld_val : gr_reg));

  // ********************************************************
  // Pin level on compare match
  // ********************************************************
  assign cmp_level = (act == ACT_LOW) ? 1'b0 : ((act == ACT_HIGH) ? 1'b1 :
                     ((act == ACT_TOGGLE) ? ~pin_reg : pin_reg));
  assign pin_next  = ((io_wr & ~run) | pwm_clr) ? io_ctrl[IO_INIT_BIT] :
                     (match ? cmp_level : pin_reg);
  assign pin_oe    = ~cap_mode & (act != ACT_NONE);
  assign pin_out   = pin_reg;
  assign gr        = gr_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gr_reg   <= GR_INIT;
      prev_reg <= PIN_INIT;
      pin_reg  <= PIN_INIT;
    end else if (ce) begin
      gr_reg   <= gr_next;
      prev_reg <= pin_in;
      pin_reg  <= pin_next;
    end
  end

endmodule : tcc_greg
`default_nettype wire

// ===== logic/tcc_timer.sv
// Top of the three-channel 16-bit timer core
`timescale 1ns/1ps
`default_nettype none
module tcc_timer
  import tcc_pkg::*;
(
  input  wire logic         MCLK,
  input  wire logic         SYS_RST,
  input  wire logic         CLK_EN,
  input  wire logic [2:0]   RUN_REG,
  input  wire logic [2:0]   SYNC_SEL_REG,
  input  wire logic [8:0]   CLEAR_SEL,
  input  wire logic [1:0]   PHASE_MODE,
  input  wire logic [2:0]   PWM_MODE,
  input  wire logic [1:0]   BUF_EN,
  input  wire logic [2:0]   COUNT_TICK,
  input  wire logic [3:0]   EXT_CLK,
  input  wire logic [2:0]   CNT_WR,
  input  wire logic [15:0]  CNT_WDATA,
  input  wire logic [7:0]   GR_WR,
  input  wire logic [15:0]  GR_WDATA,
  input  wire logic [31:0]  IO_CTRL,
  input  wire logic [7:0]   IO_WR,
  input  wire logic [2:0]   OVF_IE,
  input  wire logic [1:0]   UNF_IE,
  input  wire logic [7:0]   MATCH_IE,
  input  wire logic [2:0]   OVF_CLR,
  input  wire logic [1:0]   UNF_CLR,
  input  wire logic [7:0]   MATCH_CLR,
  input  wire logic [7:0]   PIN_IN,
  output logic      [7:0]   PIN_OUT,
  output logic      [7:0]   PIN_OE,
  output logic      [47:0]  CNT_OUT,
  output logic      [127:0] GR_OUT,
  output logic      [2:0]   OVF_FLAG,
  output logic      [1:0]   UNF_FLAG,
  output logic      [7:0]   MATCH_FLAG,
  output logic      [2:0]   OVF_IRQ,
  output logic      [1:0]   UNF_IRQ,
  output logic      [7:0]   MATCH_IRQ
);

  logic [2:0]  own_clr;
  logic [2:0]  sync_clr;
  logic [2:0]  clr_ch;
  logic [2:0]  load_ch;
  logic [2:0]  adv;
  logic [2:0]  up;
  logic [2:0]  pwm_ch;
  logic [2:0]  ovf_p;
  logic [2:0]  unf_p;
  logic [2:0]  qstep;
  logic [2:0]  qup;
  logic [2:0]  quad_en;
  logic [7:0]  evt;
  logic [7:0]  is_cap;
  logic [7:0]  ld;
  logic [15:0] gr_w [NUM_GR];
  logic [2:0]  ovf_reg;
  logic [2:0]  ovf_next;
  logic [1:0]  unf_reg;
  logic [1:0]  unf_next;
  logic [7:0]  mf_reg;
  logic [7:0]  mf_next;
  logic        any_sync_wr;

  // ********************************************************
  // Quadrature decode, channels 1 and 2
  // ********************************************************
  assign qstep[0]   = 1'b0;
  assign qup[0]     = 1'b0;
  assign quad_en[0] = 1'b0;

  genvar q;
  for (q = 1; q < NUM_CH; q++) begin : g_quad
    logic a_prev_reg;
    logic b_prev_reg;
    // Pins are taken as synchronous; one step per change of either phase
    assign qstep[q]   = EXT_CLK[2*q-2] ^ a_prev_reg ^ EXT_CLK[2*q-1] ^ b_prev_reg;
    assign qup[q]     = EXT_CLK[2*q-2] ^ b_prev_reg;
    assign quad_en[q] = PHASE_MODE[q-1];
    always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        a_prev_reg <= PIN_INIT;
        b_prev_reg <= PIN_INIT;
      end else if (CLK_EN) begin
        a_prev_reg <= EXT_CLK[2*q-2];
        b_prev_reg <= EXT_CLK[2*q-1];
      end
    end
  end

  // ********************************************************
  // Channels: clear sources, sync preset, counters
  // ********************************************************
  assign any_sync_wr = |(CNT_WR & SYNC_SEL_REG);

  genvar c;
  for (c = 0; c < NUM_CH; c++) begin : g_ch
    localparam int B = GR_BASE[c];
    logic [2:0] sel;
    logic       cd_clr;
    logic [2:0] others;
    assign sel    = CLEAR_SEL[3*c +: 3];
    assign others = SYNC_SEL_REG & ~(3'h1 << c);
    if (c == 0) begin : g_cd
      assign cd_clr = ((sel == CLR_GC) & evt[2]) | ((sel == CLR_GD) & evt[3]);
    end else begin : g_nocd
      assign cd_clr = 1'b0;
    end
    // Until a clear source is chosen the counter simply runs free
    assign own_clr[c]  = ((sel == CLR_GA) & evt[B]) | ((sel == CLR_GB) & evt[B+1])
                         | cd_clr;
    assign sync_clr[c] = SYNC_SEL_REG[c] & (sel == CLR_SYNC)
                         & |(own_clr & others);
    assign clr_ch[c]   = own_clr[c] | sync_clr[c];
    assign load_ch[c]  = CNT_WR[c] | (SYNC_SEL_REG[c] & any_sync_wr);
    assign adv[c]      = RUN_REG[c] & (quad_en[c] ? qstep[c] : COUNT_TICK[c]);
    assign up[c]       = ~quad_en[c] | qup[c];
    assign pwm_ch[c]   = PWM_MODE[c] & clr_ch[c];

    tcc_counter u_cnt (
      .clk      (MCLK),
      .rst      (SYS_RST),
      .ce       (CLK_EN),
      .adv      (adv[c]),
      .up       (up[c]),
      .load     (load_ch[c]),
      .load_val (CNT_WDATA),
      .clr      (clr_ch[c]),
      .cnt      (CNT_OUT[16*c +: 16]),
      .ovf      (ovf_p[c]),
      .unf      (unf_p[c])
    );
  end

  // ********************************************************
  // General registers and buffer pairing
  // ********************************************************
  // Channel 0 only: C buffers A, D buffers B
  assign ld[0]   = BUF_EN[0] & evt[0] & ~is_cap[0];
  assign ld[1]   = BUF_EN[1] & evt[1] & ~is_cap[1];
  assign ld[2]   = BUF_EN[0] & is_cap[0];
  assign ld[3]   = BUF_EN[1] & is_cap[1];
  assign ld[7:4] = 4'h0;

  genvar g;
  for (g = 0; g < NUM_GR; g++) begin : g_gr
    localparam int CH = (g < 4) ? 0 : ((g < 6) ? 1 : 2);
    localparam int PR = (g < 4) ? (g ^ 2) : g;

    tcc_greg u_gr (
      .clk     (MCLK),
      .rst     (SYS_RST),
      .ce      (CLK_EN),
      .cnt     (CNT_OUT[16*CH +: 16]),
      .adv     (adv[CH]),
      .run     (RUN_REG[CH]),
      .io_ctrl (IO_CTRL[4*g +: 4]),
      .io_wr   (IO_WR[g]),
      .gr_wr   (GR_WR[g]),
      .wdata   (GR_WDATA),
      .ld      (ld[g]),
      .ld_val  (gr_w[PR]),
      .pwm_clr (pwm_ch[CH]),
      .pin_in  (PIN_IN[g]),
      .gr      (gr_w[g]),
      .evt     (evt[g]),
      .is_cap  (is_cap[g]),
      .pin_out (PIN_OUT[g]),
      .pin_oe  (PIN_OE[g])
    );
    assign GR_OUT[16*g +: 16] = gr_w[g];
  end

  // ********************************************************
  // Status flags and interrupt requests
  // ********************************************************
  // Control inputs are bit fields as wide as their flags (3, 2 and 8 bits), driven directly
  // A set in the clearing cycle wins, so no event is lost
  assign ovf_next   = ovf_p | (ovf_reg & ~OVF_CLR);
  assign unf_next   = unf_p[2:1] | (unf_reg & ~UNF_CLR);
  assign mf_next    = evt | (mf_reg & ~MATCH_CLR);
  assign OVF_FLAG   = ovf_reg;
  assign UNF_FLAG   = unf_reg;
  assign MATCH_FLAG = mf_reg;
  assign OVF_IRQ    = ovf_reg & OVF_IE;
  assign UNF_IRQ    = unf_reg & UNF_IE;
  assign MATCH_IRQ  = mf_reg & MATCH_IE;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ovf_reg <= FLAG3_INIT;
      unf_reg <= FLAG2_INIT;
      mf_reg  <= FLAG8_INIT;
    end else if (CLK_EN) begin
      ovf_reg <= ovf_next;
      unf_reg <= unf_next;
      mf_reg  <= mf_next;
    end
  end

  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  sequence s_buf_match;
    CLK_EN && BUF_EN[0] && evt[0] && !is_cap[0] && !GR_WR[0];
  endsequence

  chk_ovf_flag_set: assert property (CLK_EN && ovf_p[0] |=> OVF_FLAG[0])
    else $error("Overflow did not set its flag");

  chk_ovf_irq_out: assert property (CLK_EN && ovf_p[0] && OVF_IE[0] |=> OVF_IRQ[0])
    else $error("Enabled overflow raised no request");

  chk_wrap_to_zero: assert property (CLK_EN && ovf_p[0] |=> CNT_OUT[15:0] == CNT_INIT)
    else $error("Counter did not wrap to zero");

  chk_period_clear: assert property (CLK_EN && own_clr[0] && !load_ch[0]
    |=> CNT_OUT[15:0] == CNT_INIT && MATCH_FLAG != FLAG8_INIT)
    else $error("Period match did not clear counter");

  chk_sync_preset: assert property (CLK_EN && any_sync_wr && SYNC_SEL_REG[0]
    |=> CNT_OUT[15:0] == $past(CNT_WDATA))
    else $error("Synchronous preset missed channel 0");

  chk_sync_clear: assert property (CLK_EN && SYNC_SEL_REG[1:0] == 2'h3
    && CLEAR_SEL[5:3] == CLR_SYNC && own_clr[0] && !load_ch[1]
    |=> CNT_OUT[31:16] == CNT_INIT)
    else $error("Synchronous clear missed channel 1");

  chk_halt_hold: assert property (CLK_EN && !RUN_REG[0] && !load_ch[0] && !clr_ch[0]
    |=> $stable(CNT_OUT[15:0]))
    else $error("Halted counter moved");

  chk_tick_count: assert property (CLK_EN && RUN_REG[0] && COUNT_TICK[0]
    && !load_ch[0] && !clr_ch[0] |=> CNT_OUT[15:0] == $past(CNT_OUT[15:0]) + CNT_STEP)
    else $error("Running counter missed a tick");

  chk_capture_copy: assert property (CLK_EN && is_cap[6] && !GR_WR[6]
    |=> GR_OUT[111:96] == $past(CNT_OUT[47:32]))
    else $error("Capture did not copy counter");

  chk_buffer_load: assert property (s_buf_match |=> GR_OUT[15:0] == $past(GR_OUT[47:32]))
    else $error("Buffer not moved on compare match");

  chk_pin_toggle: assert property (CLK_EN && evt[0] && !IO_CTRL[IO_CAP_BIT]
    && IO_CTRL[1:0] == ACT_TOGGLE && !pwm_ch[0] && !(IO_WR[0] && !RUN_REG[0])
    |=> PIN_OUT[0] != $past(PIN_OUT[0]))
    else $error("Toggle output did not toggle");

  chk_halt_pin: assert property (CLK_EN && !RUN_REG[0] && !IO_WR[0] && !clr_ch[0]
    |=> $stable(PIN_OUT[0]))
    else $error("Halted channel changed its pin");

  chk_unf_flag: assert property (CLK_EN && unf_p[1] |=> UNF_FLAG[0])
    else $error("Underflow did not set its flag");

  chk_cap_buffer: assert property (CLK_EN && BUF_EN[1] && is_cap[1] && !GR_WR[3]
    |=> GR_OUT[63:48] == $past(GR_OUT[31:16]))
    else $error("Capture did not push old value to buffer");

  chk_pwm_init: assert property (CLK_EN && PWM_MODE[2] && clr_ch[2]
    |=> PIN_OUT[6] == $past(IO_CTRL[26]))
    else $error("PWM clear did not load initial pin level");

  chk_freeze_hold: assert property (!CLK_EN
    |=> $stable(CNT_OUT) && $stable(GR_OUT) && $stable(MATCH_FLAG))
    else $error("State moved while clock enable was low");

endmodule : tcc_timer
`default_nettype wire

// ===== bench/tcc_host.sv
// Bus master model: whole-word writes to counters and general registers
`timescale 1ns/1ps
`default_nettype none
module tcc_host (
  input  wire logic        MCLK,
  output logic      [2:0]  CNT_WR,
  output logic      [15:0] CNT_WDATA,
  output logic      [7:0]  GR_WR,
  output logic      [15:0] GR_WDATA
);
  initial begin
    CNT_WR    = 3'h0;
    CNT_WDATA = 16'h0000;
    GR_WR     = 8'h00;
    GR_WDATA  = 16'h0000;
  end

  // Released data is inverted so a stale word is never mistaken for a write
  task automatic wr_cnt(input int ch, input logic [15:0] d);
    @(posedge MCLK);
    CNT_WR    <= 3'h1 << ch;
    CNT_WDATA <= d;
    @(posedge MCLK);
    CNT_WR    <= 3'h0;
    CNT_WDATA <= ~d;
  endtask : wr_cnt

  task automatic wr_gr(input int g, input logic [15:0] d);
    @(posedge MCLK);
    GR_WR    <= 8'h01 << g;
    GR_WDATA <= d;
    @(posedge MCLK);
    GR_WR    <= 8'h00;
    GR_WDATA <= ~d;
  endtask : wr_gr
endmodule : tcc_host
`default_nettype wire

// ===== bench/testbench.sv
// Self-checking bench for the three-channel timer core
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tcc_pkg::*;
;
  logic         MCLK = 1'b0;
  logic         SYS_RST = 1'b1;
  logic         CLK_EN = 1'b1;
  logic [2:0]   RUN_REG = 3'h0;
  logic [2:0]   SYNC_SEL_REG = 3'h0;
  logic [8:0]   CLEAR_SEL = 9'h000;
  logic [1:0]   PHASE_MODE = 2'h0;
  logic [2:0]   PWM_MODE = 3'h0;
  logic [1:0]   BUF_EN = 2'h0;
  logic [2:0]   COUNT_TICK = 3'h0;
  logic [3:0]   EXT_CLK = 4'h0;
  logic [31:0]  IO_CTRL = 32'h00000000;
  logic [7:0]   IO_WR = 8'h00;
  logic [2:0]   OVF_IE = 3'h0;
  logic [1:0]   UNF_IE = 2'h0;
  logic [7:0]   MATCH_IE = 8'h00;
  logic [2:0]   OVF_CLR = 3'h0;
  logic [1:0]   UNF_CLR = 2'h0;
  logic [7:0]   MATCH_CLR = 8'h00;
  logic [7:0]   PIN_IN = 8'h00;
  wire  [2:0]   CNT_WR;
  wire  [15:0]  CNT_WDATA;
  wire  [7:0]   GR_WR;
  wire  [15:0]  GR_WDATA;
  wire  [7:0]   PIN_OUT;
  wire  [7:0]   PIN_OE;
  wire  [47:0]  CNT_OUT;
  wire  [127:0] GR_OUT;
  wire  [2:0]   OVF_FLAG;
  wire  [1:0]   UNF_FLAG;
  wire  [7:0]   MATCH_FLAG;
  wire  [2:0]   OVF_IRQ;
  wire  [1:0]   UNF_IRQ;
  wire  [7:0]   MATCH_IRQ;
  int           seed;
  int           fail_count = 0;
  int           n_tests = 0;
  int           i;
  int           j;
  int           p;
  logic [15:0]  v;
  logic [15:0]  w;
  logic [15:0]  e;
  logic         pe;
  logic         up;
  logic         uf;
  logic         of;
  logic [1:0]   acts [6] = '{ACT_HIGH, ACT_HIGH, ACT_LOW, ACT_TOGGLE, ACT_NONE, ACT_TOGGLE};

  always #5 MCLK = ~MCLK;

  tcc_host i_tcc_host (.MCLK(MCLK), .CNT_WR(CNT_WR), .CNT_WDATA(CNT_WDATA),
    .GR_WR(GR_WR), .GR_WDATA(GR_WDATA));

  tcc_timer i_tcc_timer (.MCLK(MCLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
    .RUN_REG(RUN_REG), .SYNC_SEL_REG(SYNC_SEL_REG), .CLEAR_SEL(CLEAR_SEL),
    .PHASE_MODE(PHASE_MODE), .PWM_MODE(PWM_MODE), .BUF_EN(BUF_EN),
    .COUNT_TICK(COUNT_TICK), .EXT_CLK(EXT_CLK), .CNT_WR(CNT_WR), .CNT_WDATA(CNT_WDATA),
    .GR_WR(GR_WR), .GR_WDATA(GR_WDATA), .IO_CTRL(IO_CTRL), .IO_WR(IO_WR),
    .OVF_IE(OVF_IE), .UNF_IE(UNF_IE), .MATCH_IE(MATCH_IE), .OVF_CLR(OVF_CLR),
    .UNF_CLR(UNF_CLR), .MATCH_CLR(MATCH_CLR), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE), .CNT_OUT(CNT_OUT), .GR_OUT(GR_OUT), .OVF_FLAG(OVF_FLAG),
    .UNF_FLAG(UNF_FLAG), .MATCH_FLAG(MATCH_FLAG), .OVF_IRQ(OVF_IRQ),
    .UNF_IRQ(UNF_IRQ), .MATCH_IRQ(MATCH_IRQ));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic cyc(input int k);
    repeat (k) @(posedge MCLK);
  endtask : cyc

  // Checks land 1 ns after the edge so register updates have settled
  task automatic look(input int k);
    cyc(k);
    #1;
  endtask : look

  task automatic ck(input string nm, input logic [15:0] x, input logic [15:0] g);
    n_tests++;
    if (g !== x) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask : ck

  task automatic cf(input string nm, input logic x, input logic g);
    n_tests++;
    if (g !== x) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", nm, x, g);
    end
  endtask : cf

  function automatic logic [15:0] cv(input int c);
    return CNT_OUT[16*c +: 16];
  endfunction : cv

  function automatic logic [15:0] gv(input int g);
    return GR_OUT[16*g +: 16];
  endfunction : gv

  function automatic logic pin_exp(input logic cur, input logic [1:0] act);
    case (act)
      ACT_LOW:    return 1'b0;
      ACT_HIGH:   return 1'b1;
      ACT_TOGGLE: return ~cur;
      default:    return cur;
    endcase
  endfunction : pin_exp

  task automatic test_done;
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  // Whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge MCLK);
    fail_count++;
    test_done;
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    seed = 72;
    repeat (8) @(posedge MCLK);
    SYS_RST <= 1'b0;
    #1;
    ck("cnt2", CNT_INIT, cv(2));
    ck("gr7", GR_INIT, gv(7));
    cf("ovf0", 1'b0, OVF_FLAG[0]);
    // Free run, then tick without run bit
    p = 5 + ($random(seed) & 15);
    cyc(1);
    RUN_REG <= 3'h1;
    COUNT_TICK <= 3'h1;
    cyc(p);
    COUNT_TICK <= 3'h0;
    look(3);
    ck("free", 16'(p), cv(0));
    cyc(1);
    RUN_REG <= 3'h0;
    COUNT_TICK <= 3'h1;
    look(4);
    ck("halt", 16'(p), cv(0));
    // Overflow wrap
    i_tcc_host.wr_cnt(0, 16'hFFFE);
    OVF_IE <= 3'h1;
    RUN_REG <= 3'h1;
    look(2);
    ck("wrap", 16'h0000, cv(0));
    cf("ovf", 1'b1, OVF_FLAG[0]);
    cf("oirq", 1'b1, OVF_IRQ[0]);
    look(1);
    ck("next", 16'h0001, cv(0));
    cyc(1);
    RUN_REG <= 3'h0;
    COUNT_TICK <= 3'h0;
    OVF_CLR <= 3'h7;
    MATCH_CLR <= 8'hFF;
    cyc(1);
    OVF_CLR <= 3'h0;
    MATCH_CLR <= 8'h00;
    look(1);
    cf("oirq", 1'b0, OVF_IRQ[0]);
    // Sync preset and period clear with sync clear
    p = 4 + ($random(seed) & 7);
    i_tcc_host.wr_gr(0, 16'(p));
    CLEAR_SEL <= {3'h0, CLR_SYNC, CLR_GA};
    SYNC_SEL_REG <= 3'h3;
    IO_CTRL[3:0] <= {2'b00, ACT_TOGGLE};
    MATCH_IE <= 8'h01;
    RUN_REG <= 3'h3;
    v = 16'($random(seed));
    i_tcc_host.wr_cnt(2, v);
    i_tcc_host.wr_cnt(1, 16'h0000);
    #1;
    ck("pre0", 16'h0000, cv(0));
    ck("pre2", v, cv(2));
    cyc(1);
    COUNT_TICK <= 3'h2;
    cyc(3);
    COUNT_TICK <= 3'h3;
    cyc(p + 1);
    COUNT_TICK <= 3'h0;
    #1;
    ck("per0", 16'h0000, cv(0));
    cf("mf0", 1'b1, MATCH_FLAG[0]);
    cf("mirq0", 1'b1, MATCH_IRQ[0]);
    cf("pin0", 1'b1, PIN_OUT[0]);
    ck("sclr1", 16'h0000, cv(1));
    // Compare actions on a periodic channel, then halt
    i_tcc_host.wr_gr(4, 16'(p));
    CLEAR_SEL <= {3'h0, CLR_GA, 3'h0};
    SYNC_SEL_REG <= 3'h0;
    RUN_REG <= 3'h2;
    i_tcc_host.wr_cnt(1, 16'h0000);
    pe = PIN_INIT;
    for (i = 0; i < 6; i++) begin
      IO_CTRL[19:16] <= {2'b00, acts[i]};
      COUNT_TICK <= 3'h2;
      cyc(p + 1);
      COUNT_TICK <= 3'h0;
      #1;
      pe = pin_exp(pe, acts[i]);
      cf("pin4", pe, PIN_OUT[4]);
      cf("oe4", acts[i] != ACT_NONE, PIN_OE[4]);
      cyc(1);
    end
    RUN_REG <= 3'h0;
    COUNT_TICK <= 3'h2;
    look(p + 2);
    cf("keep4", pe, PIN_OUT[4]);
    ck("stop1", 16'h0000, cv(1));
    // Capture edges on a stopped counter
    cyc(1);
    COUNT_TICK <= 3'h0;
    CLEAR_SEL <= 9'h000;
    e = GR_INIT;
    for (i = 1; i < 4; i++) begin
      IO_CTRL[27:24] <= {2'b10, i[1:0]};
      for (j = 0; j < 2; j++) begin
        v = 16'($random(seed));
        i_tcc_host.wr_cnt(2, v);
        PIN_IN[6] <= ~PIN_IN[6];
        look(3);
        if (i[j])
          e = v;
        ck("gr6", e, gv(6));
        cf("cap6", i[j], MATCH_FLAG[6]);
        cyc(1);
        MATCH_CLR <= 8'h40;
        cyc(1);
        MATCH_CLR <= 8'h00;
      end
    end
    // Buffered capture, then buffered compare
    w = 16'($random(seed));
    i_tcc_host.wr_gr(1, w);
    BUF_EN <= 2'h2;
    IO_CTRL[7:4] <= {2'b10, EDGE_RISE};
    v = 16'($random(seed));
    i_tcc_host.wr_cnt(0, v);
    PIN_IN[1] <= 1'b1;
    look(3);
    ck("gr1", v, gv(1));
    ck("gr3", w, gv(3));
    w = 16'(4 + ($random(seed) & 7));
    i_tcc_host.wr_gr(2, w);
    BUF_EN <= 2'h1;
    CLEAR_SEL <= {6'h00, CLR_GA};
    RUN_REG <= 3'h1;
    i_tcc_host.wr_cnt(0, 16'h0000);
    COUNT_TICK <= 3'h1;
    cyc(p + 1);
    COUNT_TICK <= 3'h0;
    #1;
    ck("gr0", w, gv(0));
    ck("per0b", 16'h0000, cv(0));
    // Quadrature counting on channel 1
    cyc(1);
    CLEAR_SEL <= 9'h000;
    PHASE_MODE <= 2'h1;
    UNF_IE <= 2'h1;
    RUN_REG <= 3'h2;
    i_tcc_host.wr_cnt(1, 16'h0001);
    e = 16'h0001;
    uf = 1'b0;
    of = 1'b0;
    for (i = 0; i < 8; i++) begin
      up = (i == 2) || (i > 2 && ($random(seed) & 1));
      cyc(1);
      EXT_CLK[1:0] <= up ? {EXT_CLK[0], ~EXT_CLK[1]} : {~EXT_CLK[0], EXT_CLK[1]};
      of = of | (up && e == 16'hFFFF);
      uf = uf | (!up && e == 16'h0000);
      e = up ? e + 16'h0001 : e - 16'h0001;
      look(3);
      ck("quad", e, cv(1));
    end
    cf("unf1", uf, UNF_FLAG[0]);
    cf("uirq1", uf, UNF_IRQ[0]);
    cf("ovf1", of, OVF_FLAG[1]);
    // All three channels preset together
    cyc(1);
    SYNC_SEL_REG <= 3'h7;
    RUN_REG <= 3'h0;
    v = 16'($random(seed));
    i_tcc_host.wr_cnt(2, v);
    #1;
    ck("all0", v, cv(0));
    ck("all1", v, cv(1));
    // Pin control written while halted, then PWM on channel 2
    cyc(1);
    SYNC_SEL_REG <= 3'h0;
    IO_CTRL[31:24] <= {4'h0, 2'b01, ACT_LOW};
    IO_WR <= 8'h40;
    cyc(1);
    IO_WR <= 8'h00;
    look(1);
    cf("init6", 1'b1, PIN_OUT[6]);
    w = 16'(1 + ($random(seed) & 3));
    i_tcc_host.wr_gr(6, w);
    i_tcc_host.wr_gr(7, 16'h0008);
    PWM_MODE <= 3'h4;
    CLEAR_SEL <= {CLR_GB, 6'h00};
    RUN_REG <= 3'h4;
    i_tcc_host.wr_cnt(2, 16'h0000);
    COUNT_TICK <= 3'h4;
    cyc(int'(w) + 1);
    #1;
    cf("duty6", 1'b0, PIN_OUT[6]);
    cyc(8 - int'(w));
    COUNT_TICK <= 3'h0;
    #1;
    cf("pwm6", 1'b1, PIN_OUT[6]);
    ck("per2", 16'h0000, cv(2));
    // Clock enable low drops a write and a tick
    cyc(1);
    CLK_EN <= 1'b0;
    COUNT_TICK <= 3'h4;
    v = 16'($random(seed));
    i_tcc_host.wr_cnt(2, v);
    look(2);
    ck("frz2", 16'h0000, cv(2));
    // Reset again in mid-run
    cyc(1);
    CLK_EN <= 1'b1;
    SYS_RST <= 1'b1;
    cyc(2);
    SYS_RST <= 1'b0;
    #1;
    ck("rst0", CNT_INIT, cv(0));
    ck("rst6", GR_INIT, gv(6));
    cf("rmf6", 1'b0, MATCH_FLAG[6]);
    cf("rovf1", 1'b0, OVF_FLAG[1]);
    cf("rpin6", PIN_INIT, PIN_OUT[6]);
    test_done;
  end
endmodule : testbench
`default_nettype wire
